//--- core/shae_defines.vh
`ifndef SHAE_DEFINES_VH
`define SHAE_DEFINES_VH

// command opcode and mode codes
`define SHAE_OPCODE        8'h47
`define SHAE_MODE_START    3'h0
`define SHAE_MODE_UPDATE   3'h1
`define SHAE_MODE_END      3'h2
`define SHAE_MODE_PUBLIC   3'h3
`define SHAE_MODE_HSTART   3'h4
`define SHAE_MODE_HEND     3'h5

// status answers
`define SHAE_STAT_OK       8'h00
`define SHAE_ERR_PARSE     8'h03
`define SHAE_ERR_EXEC      8'h0F

// byte counts
`define SHAE_BLOCK_BYTES   7'h40
`define SHAE_HDR_BYTES     3'h4
`define SHAE_PAD_LIMIT     6'h38
`define SHAE_PAD_BYTE      8'h80
`define SHAE_IPAD          {64{8'h36}}
`define SHAE_OPAD          {64{8'h5C}}
// bit length of the outer hmac message: one key block plus 32 digest bytes
`define SHAE_OUTER_BITS    64'h0000000000000300

// initial hash value
`define SHAE_H0 {32'h6A09E667, 32'hBB67AE85, 32'h3C6EF372, 32'hA54FF53A, \
                 32'h510E527F, 32'h9B05688C, 32'h1F83D9AB, 32'h5BE0CD19}

`endif

//--- core/shae_core.v
`timescale 1ns/1ps
`default_nettype none

module shae_core (
  input  wire         sys_clk,
  input  wire         rstn,
  input  wire         start,
  input  wire [511:0] blockIn,
  input  wire [255:0] stateIn,
  output reg          done,
  output reg  [255:0] stateOut
);

  localparam [2047:0] K_TAB = {
    32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5, 32'h3956C25B, 32'h59F111F1,
    32'h923F82A4, 32'hAB1C5ED5, 32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
    32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174, 32'hE49B69C1, 32'hEFBE4786,
    32'h0FC19DC6, 32'h240CA1CC, 32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
    32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7, 32'hC6E00BF3, 32'hD5A79147,
    32'h06CA6351, 32'h14292967, 32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
    32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85, 32'hA2BFE8A1, 32'hA81A664B,
    32'hC24B8B70, 32'hC76C51A3, 32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
    32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5, 32'h391C0CB3, 32'h4ED8AA4A,
    32'h5B9CCA4F, 32'h682E6FF3, 32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
    32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};

  function [31:0] bigSig0;
    input [31:0] x;
    bigSig0 = {x[1:0], x[31:2]} ^ {x[12:0], x[31:13]} ^ {x[21:0], x[31:22]};
  endfunction

  function [31:0] bigSig1;
    input [31:0] x;
    bigSig1 = {x[5:0], x[31:6]} ^ {x[10:0], x[31:11]} ^ {x[24:0], x[31:25]};
  endfunction

  function [31:0] smlSig0;
    input [31:0] x;
    smlSig0 = {x[6:0], x[31:7]} ^ {x[17:0], x[31:18]} ^ {3'h0, x[31:3]};
  endfunction

  function [31:0] smlSig1;
    input [31:0] x;
    smlSig1 = {x[16:0], x[31:17]} ^ {x[18:0], x[31:19]} ^ {10'h000, x[31:10]};
  endfunction

  reg  [255:0] hInit_q;
  reg  [511:0] sched_q;
  reg  [31:0]  a_q, b_q, c_q, d_q, e_q, f_q, g_q, h_q;
  reg  [5:0]   round_q;
  reg          run_q;

  wire [31:0]  kNow  = K_TAB[{~round_q, 5'h00} +: 32];
  wire [31:0]  wNow  = sched_q[511:480];
  wire [31:0]  wNext = smlSig1(sched_q[63:32]) + sched_q[223:192]
                       + smlSig0(sched_q[479:448]) + wNow;
  wire [31:0]  t1    = h_q + bigSig1(e_q) + ((e_q & f_q) ^ (~e_q & g_q)) + kNow + wNow;
  wire [31:0]  t2    = bigSig0(a_q) + ((a_q & b_q) ^ (a_q & c_q) ^ (b_q & c_q));
  wire [31:0]  aNew  = t1 + t2;
  wire [31:0]  eNew  = d_q + t1;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hInit_q  <= 256'h0;
      sched_q  <= 512'h0;
      {a_q, b_q, c_q, d_q, e_q, f_q, g_q, h_q} <= 256'h0;
      round_q  <= 6'h00;
      run_q    <= 1'b0;
      done     <= 1'b0;
      stateOut <= 256'h0;
    end else begin
      done <= 1'b0;
      if (start && !run_q) begin
        hInit_q <= stateIn;
        sched_q <= blockIn;
        {a_q, b_q, c_q, d_q, e_q, f_q, g_q, h_q} <= stateIn;
        round_q <= 6'h00;
        run_q   <= 1'b1;
      end else if (run_q) begin
        a_q <= aNew;
        b_q <= a_q;
        c_q <= b_q;
        d_q <= c_q;
        e_q <= eNew;
        f_q <= e_q;
        g_q <= f_q;
        h_q <= g_q;
        sched_q <= {sched_q[479:0], wNext};
        round_q <= round_q + 6'h01;
        if (round_q == 6'h3F) begin
          run_q    <= 1'b0;
          done     <= 1'b1;
          stateOut <= {hInit_q[255:224] + aNew, hInit_q[223:192] + a_q,
                       hInit_q[191:160] + b_q,  hInit_q[159:128] + c_q,
                       hInit_q[127:96]  + eNew, hInit_q[95:64]   + e_q,
                       hInit_q[63:32]   + f_q,  hInit_q[31:0]    + g_q};
        end
      end
    end
  end

endmodule // shae_core

`default_nettype wire

//--- core/shae_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "shae_defines.vh"

// Function
// - mode 000 resets the context to the initial hash; zero length, no bytes
// - mode 001 absorbs exactly one full 64-byte block into the context
// - mode 010 pads and finishes over 0..63 bytes; digest to scratch and response
// - mode 011 absorbs the 64-byte public key of the named slot, else error
// - mode 100 starts a keyed hash with slot from length; key must allow hashing
// - mode 101 finishes the keyed hash with the start key; digest to both places
// - up to 255 blocks (254 keyed) between start and finish before the length wraps; keyed flow updates alike
// - any error or foreign command drops the context and invalidates scratch
// - answer is the 32-byte digest for 010/101, else one status byte; foreign or short-header frames get no answer
// - cert check passes only if key block index and block total match format
// - finished digest stays in the scratch register for a later cert check
module shae_engine (
  input  wire         sys_clk,
  input  wire         rstn,
  input  wire         linkClk,
  input  wire         linkData,
  input  wire         linkFrame,
  input  wire [15:0]  slotIsPubKey,
  input  wire [15:0]  slotHashOk,
  input  wire [511:0] slotData,
  input  wire [7:0]   certTemplateFormat,
  output reg  [3:0]   slotSel,
  output reg          respValid,
  output reg          respDigest,
  output reg  [7:0]   respStatus,
  output reg  [255:0] digestOut,
  output reg  [255:0] scratchKeyRegister,
  output reg          scratchValid,
  output reg          certPubKeyOk
);

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_RX    = 4'h1;
  localparam [3:0] S_EXEC  = 4'h2;
  localparam [3:0] S_WAIT  = 4'h3;
  localparam [3:0] S_OK    = 4'h4;
  localparam [3:0] S_PADB  = 4'h5;
  localparam [3:0] S_FINAL = 4'h6;
  localparam [3:0] S_OUTER = 4'h7;
  localparam [3:0] S_DONE  = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // link synchronisers
  reg        clkS1_q, clkS2_q, clkS3_q;
  reg        datS1_q, datS2_q;
  reg        frmS1_q, frmS2_q, frmS3_q;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {clkS1_q, clkS2_q, clkS3_q} <= 3'h0;
      {datS1_q, datS2_q}          <= 2'h0;
      {frmS1_q, frmS2_q, frmS3_q} <= 3'h0;
    end else begin
      clkS1_q <= linkClk;
      clkS2_q <= clkS1_q;
      clkS3_q <= clkS2_q;
      datS1_q <= linkData;
      datS2_q <= datS1_q;
      frmS1_q <= linkFrame;
      frmS2_q <= frmS1_q;
      frmS3_q <= frmS2_q;
    end
  end

  wire       clkRise  = clkS2_q & ~clkS3_q;
  wire       frmRise  = frmS2_q & ~frmS3_q;
  wire       frmFall  = ~frmS2_q & frmS3_q;

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg  [3:0]   state_q, ret_q;
  reg  [6:0]   shift_q;
  reg  [2:0]   bitCnt_q, hdrCnt_q;
  reg  [6:0]   rxCnt_q;
  reg  [7:0]   opcode_q, mode_q, p2Lo_q, p2Hi_q;
  reg  [511:0] msgBuf_q;
  reg  [255:0] ctx_q, inner_q;
  reg          ctxValid_q, keyed_q;
  reg  [3:0]   keySlot_q;
  reg  [7:0]   blkCnt_q;
  reg  [4:0]   pubIdx_q;
  reg          pubSeen_q;
  reg          coreStart_q;
  reg  [511:0] coreBlock_q;
  wire         coreDone;
  wire [255:0] coreOut;

  wire [7:0]   rxByte  = {shift_q, datS2_q};
  wire [8:0]   wrPos   = {~rxCnt_q[5:0], 3'h0};
  wire [15:0]  second_parameter  = {p2Hi_q, p2Lo_q};
  wire [2:0]   modeLow = mode_q[2:0];
  wire [7:0]   lenBlks = blkCnt_q + {7'h00, keyed_q};
  wire [63:0]  lenBits = {47'h0, lenBlks, rxCnt_q[5:0], 3'h0};
  wire [511:0] keyBlock = {slotData[511:256], 256'h0};

  // final padded block(s) over the trailing bytes held in the buffer
  reg  [511:0] padA, padB;
  integer k;
  always @* begin
    padA = 512'h0;
    for (k = 0; k < 64; k = k + 1) begin
      if (k < rxCnt_q)
        padA[(63 - k) * 8 +: 8] = msgBuf_q[(63 - k) * 8 +: 8];
      else if (k == rxCnt_q)
        padA[(63 - k) * 8 +: 8] = `SHAE_PAD_BYTE;
    end
    if (rxCnt_q[5:0] < `SHAE_PAD_LIMIT)
      padA[63:0] = lenBits;
    padB = {448'h0, lenBits};
  end

  // command checks
  wire modeBad  = (mode_q[7:3] != 5'h00) || (modeLow[2:1] == 2'h3);
  wire finMode  = (modeLow == `SHAE_MODE_END) || (modeLow == `SHAE_MODE_HEND);
  reg  cmdErr;
  reg  [7:0] errCode;
  always @* begin
    cmdErr  = 1'b0;
    errCode = `SHAE_ERR_PARSE;
    if (modeBad) begin
      cmdErr = 1'b1;
    end else if (modeLow == `SHAE_MODE_START) begin
      cmdErr = (second_parameter != 16'h0000) || (rxCnt_q != 7'h00);
    end else if (modeLow == `SHAE_MODE_UPDATE) begin
      cmdErr = (second_parameter != {9'h000, `SHAE_BLOCK_BYTES}) ||
               (rxCnt_q != `SHAE_BLOCK_BYTES);
      if (!cmdErr && !ctxValid_q) begin
        cmdErr  = 1'b1;
        errCode = `SHAE_ERR_EXEC;
      end
    end else if (finMode) begin
      cmdErr = (second_parameter > 16'h003F) || (second_parameter[6:0] != rxCnt_q);
      if (!cmdErr && (!ctxValid_q || (keyed_q != modeLow[2]))) begin
        cmdErr  = 1'b1;
        errCode = `SHAE_ERR_EXEC;
      end
    end else if (modeLow == `SHAE_MODE_PUBLIC) begin
      cmdErr = (rxCnt_q != 7'h00) || (second_parameter[15:4] != 12'h000);
      if (!cmdErr && (!ctxValid_q || !slotIsPubKey[slotSel])) begin
        cmdErr  = 1'b1;
        errCode = `SHAE_ERR_EXEC;
      end
    end else begin
      cmdErr = (rxCnt_q != 7'h00) || (second_parameter[15:4] != 12'h000);
      if (!cmdErr && !slotHashOk[slotSel]) begin
        cmdErr  = 1'b1;
        errCode = `SHAE_ERR_EXEC;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive and command sequencing
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= S_IDLE;
      ret_q        <= S_IDLE;
      shift_q      <= 7'h00;
      bitCnt_q     <= 3'h0;
      hdrCnt_q     <= 3'h0;
      rxCnt_q      <= 7'h00;
      opcode_q     <= 8'h00;
      mode_q       <= 8'h00;
      p2Lo_q       <= 8'h00;
      p2Hi_q       <= 8'h00;
      msgBuf_q     <= 512'h0;
      ctx_q        <= 256'h0;
      inner_q      <= 256'h0;
      ctxValid_q   <= 1'b0;
      keyed_q      <= 1'b0;
      keySlot_q    <= 4'h0;
      blkCnt_q     <= 8'h00;
      pubIdx_q     <= 5'h00;
      pubSeen_q    <= 1'b0;
      coreStart_q  <= 1'b0;
      coreBlock_q  <= 512'h0;
      slotSel      <= 4'h0;
      respValid    <= 1'b0;
      respDigest   <= 1'b0;
      respStatus   <= 8'h00;
      digestOut    <= 256'h0;
      scratchKeyRegister <= 256'h0;
      scratchValid <= 1'b0;
      certPubKeyOk <= 1'b0;
    end else begin
      respValid   <= 1'b0;
      coreStart_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (frmRise) begin
            state_q  <= S_RX;
            bitCnt_q <= 3'h0;
            hdrCnt_q <= 3'h0;
            rxCnt_q  <= 7'h00;
            opcode_q <= 8'h00;
            msgBuf_q <= 512'h0;
          end
        end
        S_RX: begin
          if (frmFall) begin
            state_q <= S_EXEC;
            slotSel <= (mode_q[2:0] == `SHAE_MODE_HEND) ? keySlot_q : p2Lo_q[3:0];
          end else if (clkRise) begin
            shift_q  <= rxByte[6:0];
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              if (hdrCnt_q < `SHAE_HDR_BYTES) begin
                hdrCnt_q <= hdrCnt_q + 3'h1;
                case (hdrCnt_q[1:0])
                  2'h0: opcode_q <= rxByte;
                  2'h1: mode_q   <= rxByte;
                  2'h2: p2Lo_q   <= rxByte;
                  default: p2Hi_q <= rxByte;
                endcase
              end else if (rxCnt_q < `SHAE_BLOCK_BYTES) begin
                msgBuf_q[wrPos +: 8] <= rxByte;
                rxCnt_q <= rxCnt_q + 7'h01;
              end else begin
                rxCnt_q <= `SHAE_BLOCK_BYTES + 7'h01;
              end
            end
          end
        end
        S_EXEC: begin
          if ((opcode_q != `SHAE_OPCODE) || (hdrCnt_q != `SHAE_HDR_BYTES)) begin
            ctxValid_q   <= 1'b0;
            scratchValid <= 1'b0;
            state_q      <= S_IDLE;
          end else if (cmdErr) begin
            ctxValid_q   <= 1'b0;
            scratchValid <= 1'b0;
            respValid    <= 1'b1;
            respDigest   <= 1'b0;
            respStatus   <= errCode;
            state_q      <= S_IDLE;
          end else begin
            case (modeLow)
              `SHAE_MODE_START: begin
                ctx_q        <= `SHAE_H0;
                ctxValid_q   <= 1'b1;
                keyed_q      <= 1'b0;
                blkCnt_q     <= 8'h00;
                pubSeen_q    <= 1'b0;
                scratchValid <= 1'b0;
                state_q      <= S_OK;
              end
              `SHAE_MODE_UPDATE: begin
                coreBlock_q <= msgBuf_q;
                coreStart_q <= 1'b1;
                blkCnt_q    <= blkCnt_q + 8'h01;
                ret_q       <= S_OK;
                state_q     <= S_WAIT;
              end
              `SHAE_MODE_PUBLIC: begin
                coreBlock_q <= slotData;
                coreStart_q <= 1'b1;
                pubIdx_q    <= blkCnt_q[4:0];
                pubSeen_q   <= 1'b1;
                blkCnt_q    <= blkCnt_q + 8'h01;
                ret_q       <= S_OK;
                state_q     <= S_WAIT;
              end
              `SHAE_MODE_HSTART: begin
                ctx_q        <= `SHAE_H0;
                ctxValid_q   <= 1'b1;
                keyed_q      <= 1'b1;
                keySlot_q    <= slotSel;
                blkCnt_q     <= 8'h00;
                pubSeen_q    <= 1'b0;
                scratchValid <= 1'b0;
                coreBlock_q  <= keyBlock ^ `SHAE_IPAD;
                coreStart_q  <= 1'b1;
                ret_q        <= S_OK;
                state_q      <= S_WAIT;
              end
              default: begin
                coreBlock_q <= padA;
                coreStart_q <= 1'b1;
                ret_q       <= (rxCnt_q[5:0] < `SHAE_PAD_LIMIT) ? S_FINAL : S_PADB;
                state_q     <= S_WAIT;
              end
            endcase
          end
        end
        S_WAIT: begin
          if (coreDone) begin
            ctx_q   <= coreOut;
            state_q <= ret_q;
          end
        end
        S_PADB: begin
          coreBlock_q <= padB;
          coreStart_q <= 1'b1;
          ret_q       <= S_FINAL;
          state_q     <= S_WAIT;
        end
        S_FINAL: begin
          if (keyed_q) begin
            inner_q     <= ctx_q;
            ctx_q       <= `SHAE_H0;
            coreBlock_q <= keyBlock ^ `SHAE_OPAD;
            coreStart_q <= 1'b1;
            ret_q       <= S_OUTER;
            state_q     <= S_WAIT;
          end else begin
            state_q <= S_DONE;
          end
        end
        S_OUTER: begin
          coreBlock_q <= {inner_q, `SHAE_PAD_BYTE, 184'h0, `SHAE_OUTER_BITS};
          coreStart_q <= 1'b1;
          ret_q       <= S_DONE;
          state_q     <= S_WAIT;
        end
        S_DONE: begin
          digestOut          <= ctx_q;
          scratchKeyRegister <= ctx_q;
          scratchValid       <= 1'b1;
          certPubKeyOk       <= pubSeen_q &&
                                (pubIdx_q == {1'b0, certTemplateFormat[3:0]}) &&
                                (blkCnt_q == {4'h0, certTemplateFormat[7:4]});
          ctxValid_q         <= 1'b0;
          respValid          <= 1'b1;
          respDigest         <= 1'b1;
          respStatus         <= `SHAE_STAT_OK;
          state_q            <= S_IDLE;
        end
        S_OK: begin
          respValid  <= 1'b1;
          respDigest <= 1'b0;
          respStatus <= `SHAE_STAT_OK;
          state_q    <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compression round engine
  shae_core u_core (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .start    (coreStart_q),
    .blockIn  (coreBlock_q),
    .stateIn  (ctx_q),
    .done     (coreDone),
    .stateOut (coreOut)
  );

endmodule // shae_engine

`default_nettype wire

//--- dv/shae_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module shae_engine_asserts (
  input wire logic         sys_clk,
  input wire logic         rstn,
  input wire logic         linkClk,
  input wire logic         linkData,
  input wire logic         linkFrame,
  input wire logic [15:0]  slotIsPubKey,
  input wire logic [15:0]  slotHashOk,
  input wire logic [511:0] slotData,
  input wire logic [7:0]   certTemplateFormat,
  input wire logic [3:0]   slotSel,
  input wire logic         respValid,
  input wire logic         respDigest,
  input wire logic [7:0]   respStatus,
  input wire logic [255:0] digestOut,
  input wire logic [255:0] scratchKeyRegister,
  input wire logic         scratchValid,
  input wire logic         certPubKeyOk
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_pulse; respValid |=> !respValid; endproperty
  a_pulse: assert property (p_pulse) else $error("answer pulse longer than one cycle");
  property p_codes; respValid && !respDigest |-> respStatus inside {8'h00, 8'h03, 8'h0F}; endproperty
  a_codes: assert property (p_codes) else $error("unknown status code");
  property p_copy; respValid && respDigest |-> scratchKeyRegister == digestOut; endproperty
  a_copy: assert property (p_copy) else $error("scratch differs from digest");
  property p_valid; respValid && respDigest |-> ##[0:1] scratchValid; endproperty
  a_valid: assert property (p_valid) else $error("scratch not valid after finish");
  property p_errDrop; respValid && !respDigest && respStatus != 8'h00 |-> ##[0:1] !scratchValid;
  endproperty
  a_errDrop: assert property (p_errDrop) else $error("scratch valid after error");
  property p_keep; !respValid |-> $stable(scratchKeyRegister); endproperty
  a_keep: assert property (p_keep) else $error("scratch changed without answer");
  property p_hold; !respValid |-> $stable(digestOut) && $stable(respDigest) && $stable(respStatus);
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed between answers");
  property p_rise; $rose(scratchValid) |-> respValid && respDigest; endproperty
  a_rise: assert property (p_rise) else $error("scratch became valid without digest");
  property p_cert; !respValid |-> $stable(certPubKeyOk); endproperty
  a_cert: assert property (p_cert) else $error("cert flag changed without answer");
endmodule // shae_engine_asserts

bind shae_engine shae_engine_asserts chk_u (
  .sys_clk(sys_clk), .rstn(rstn), .linkClk(linkClk), .linkData(linkData),
  .linkFrame(linkFrame), .slotIsPubKey(slotIsPubKey), .slotHashOk(slotHashOk),
  .slotData(slotData), .certTemplateFormat(certTemplateFormat), .slotSel(slotSel),
  .respValid(respValid), .respDigest(respDigest), .respStatus(respStatus),
  .digestOut(digestOut), .scratchKeyRegister(scratchKeyRegister),
  .scratchValid(scratchValid), .certPubKeyOk(certPubKeyOk));

`default_nettype wire

//--- dv/shae_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module shae_host_model (
  output var logic linkClk,
  output var logic linkData,
  output var logic linkFrame
);
  initial begin
    linkClk = 1'b0;
    linkData = 1'b0;
    linkFrame = 1'b0;
  end

  // link clock stands low between frames; 125 ns period inside a frame
  task automatic sendFrame(input logic [7:0] q[$]);
    int i;
    int b;
    #250.0;
    linkFrame = 1'b1;
    for (i = 0; i < q.size(); i++) begin
      for (b = 7; b >= 0; b--) begin
        linkData = q[i][b];
        #62.5 linkClk = 1'b1;
        #62.5 linkClk = 1'b0;
      end
    end
    #62.5 linkFrame = 1'b0;
    // released line must not keep showing the last bit
    linkData = ~linkData;
  endtask
endmodule // shae_host_model

`default_nettype wire

//--- dv/shae_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [255:0] EMPTY_DIG =
    256'hE3B0C44298FC1C149AFBF4C8996FB92427AE41E4649B934CA495991B7852B855;
  localparam logic [255:0] ABC_DIG =
    256'hBA7816BF8F01CFEA414140DE5DAE2223B00361A396177A9CB410FF61F20015AD;
  logic         sys_clk;
  logic         rstn;
  logic         linkClk;
  logic         linkData;
  logic         linkFrame;
  logic [15:0]  slotIsPubKey;
  logic [15:0]  slotHashOk;
  logic [511:0] slotData;
  logic [7:0]   certTemplateFormat;
  logic [3:0]   slotSel;
  logic         respValid;
  logic         respDigest;
  logic [7:0]   respStatus;
  logic [255:0] digestOut;
  logic [255:0] scratchKeyRegister;
  logic         scratchValid;
  logic         certPubKeyOk;
  int           error_cnt;
  int           samples_checked;

  shae_host_model hostU (.linkClk(linkClk), .linkData(linkData), .linkFrame(linkFrame));

  shae_engine dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .linkClk(linkClk), .linkData(linkData),
    .linkFrame(linkFrame), .slotIsPubKey(slotIsPubKey), .slotHashOk(slotHashOk),
    .slotData(slotData), .certTemplateFormat(certTemplateFormat), .slotSel(slotSel),
    .respValid(respValid), .respDigest(respDigest), .respStatus(respStatus),
    .digestOut(digestOut), .scratchKeyRegister(scratchKeyRegister),
    .scratchValid(scratchValid), .certPubKeyOk(certPubKeyOk));

  // slot contents follow the selected index so a wrong slot shows
  assign slotData = {32{slotSel, 12'hA5C}};

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one command frame; waits for the answer pulse of hash commands
  task automatic run(input logic [7:0] op, input logic [7:0] mode, input logic [15:0] p2,
                     input int n, input logic [7:0] f);
    logic [7:0] q[$];
    int k;
    q = {op, mode, p2[7:0], p2[15:8]};
    for (k = 0; k < n; k++)
      q.push_back(f + k[7:0]);
    // start frames off the sampling edge
    @(posedge sys_clk);
    #1;
    hostU.sendFrame(q);
    if (op == 8'h47) begin
      for (k = 0; k < 3000 && respValid !== 1'b1; k++)
        @(negedge sys_clk);
      chk("answer", respValid, 1'b1);
    end else begin
      repeat (30) @(negedge sys_clk);
    end
  endtask

  task automatic st(input logic [7:0] e);
    chk("status", respStatus, e);
    chk("digestFlag", respDigest, 1'b0);
  endtask

  task automatic setFmt(input logic [7:0] v);
    @(posedge sys_clk);
    #1 certTemplateFormat = v;
  endtask

  ////////////////////////////////////////
  task automatic tPlain;
    run(8'h47, 8'h00, 16'h0000, 0, 8'h00);
    st(8'h00);
    run(8'h47, 8'h02, 16'h0000, 0, 8'h00);
    chk("digestFlag", respDigest, 1'b1);
    chk("digest", digestOut, EMPTY_DIG);
    chk("scratch", scratchKeyRegister, EMPTY_DIG);
    chk("scratchValid", scratchValid, 1'b1);
    run(8'h47, 8'h00, 16'h0000, 0, 8'h00);
    run(8'h47, 8'h02, 16'h0003, 3, 8'h61);
    chk("digest", digestOut, ABC_DIG);
  endtask

  task automatic tUpdate;
    run(8'h47, 8'h00, 16'h0000, 0, 8'h00);
    run(8'h47, 8'h01, 16'h0040, 64, 8'h10);
    st(8'h00);
    run(8'h47, 8'h01, 16'h0040, 64, 8'h50);
    st(8'h00);
    run(8'h47, 8'h01, 16'h003F, 63, 8'h00);
    st(8'h03);
    chk("scratchValid", scratchValid, 1'b0);
    run(8'h47, 8'h02, 16'h0000, 0, 8'h00);
    st(8'h0F);
  endtask

  task automatic tMode;
    logic [7:0] bad[4] = '{8'h08, 8'h06, 8'h07, 8'hF1};
    foreach (bad[i]) begin
      run(8'h47, bad[i], 16'h0000, 0, 8'h00);
      st(8'h03);
    end
    run(8'h47, 8'h00, 16'h0001, 1, 8'h00);
    st(8'h03);
    run(8'h47, 8'h02, 16'h0040, 0, 8'h00);
    st(8'h03);
  endtask

  task automatic tPublic;
    logic [7:0] fmt[2] = '{8'h10, 8'h11};
    run(8'h47, 8'h00, 16'h0000, 0, 8'h00);
    run(8'h47, 8'h03, 16'h0004, 0, 8'h00);
    st(8'h0F);
    foreach (fmt[i]) begin
      setFmt(fmt[i]);
      run(8'h47, 8'h00, 16'h0000, 0, 8'h00);
      run(8'h47, 8'h03, 16'h0005, 0, 8'h00);
      st(8'h00);
      run(8'h47, 8'h02, 16'h0000, 0, 8'h00);
      chk("certOk", certPubKeyOk, (i == 0));
    end
  endtask

  task automatic tHmac;
    run(8'h47, 8'h04, 16'h0003, 0, 8'h00);
    st(8'h0F);
    run(8'h47, 8'h04, 16'h0002, 0, 8'h00);
    st(8'h00);
    run(8'h47, 8'h01, 16'h0040, 64, 8'h20);
    st(8'h00);
    run(8'h47, 8'h05, 16'h0002, 2, 8'h61);
    chk("digestFlag", respDigest, 1'b1);
    chk("scratch", scratchKeyRegister, digestOut);
    chk("scratchValid", scratchValid, 1'b1);
    run(8'h47, 8'h07, 16'h0000, 0, 8'h00);
    st(8'h03);
    chk("scratchValid", scratchValid, 1'b0);
  endtask

  task automatic tForeign;
    run(8'h47, 8'h00, 16'h0000, 0, 8'h00);
    run(8'h02, 8'h00, 16'h0000, 0, 8'h00);
    run(8'h47, 8'h02, 16'h0000, 0, 8'h00);
    st(8'h0F);
    run(8'h47, 8'h00, 16'h0000, 0, 8'h00);
    run(8'h47, 8'h02, 16'h0000, 0, 8'h00);
    run(8'h1B, 8'h00, 16'h0000, 0, 8'h00);
    chk("scratchValid", scratchValid, 1'b0);
  endtask

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rstn = 1'b0;
    slotIsPubKey = 16'h0020;
    slotHashOk = 16'h0004;
    certTemplateFormat = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    tPlain();
    tUpdate();
    tMode();
    tPublic();
    tHmac();
    tForeign();
    conclude();
  end

  initial begin
    #900000;
    error_cnt++;
    conclude();
  end
endmodule // tb

`default_nettype wire
